// file: inc/lcdcmd_pkg.sv
// Package with command codes, field positions and limits of the LCD command decoder
`default_nettype none
package lcdcmd_pkg;
    // Command byte field layout
    localparam int CMD_W       = 8;              // Width of every received byte
    localparam int OP5_HI      = 7;              // Upper five-bit opcode field, high bit
    localparam int OP5_LO      = 3;              // Upper five-bit opcode field, low bit
    localparam int OP2_LO      = 6;              // Two-bit opcode field, low bit
    localparam int DP_W        = 6;              // Display pointer width
    localparam int PP_W        = 3;              // PWM pointer width
    localparam int GPO_N       = 6;              // Number of static outputs
    localparam int GPO_GRP     = 3;              // Static bits per command
    localparam int RAM_DEPTH   = 44;             // Display RAM bytes
    localparam int BUF_DEPTH   = 2;              // Entries of the data buffer
    // Opcodes
    localparam logic [4:0] OP_GPO_LOW  = 5'h0C;  // Static outputs 0 to 2
    localparam logic [4:0] OP_GPO_HIGH = 5'h0D;  // Static outputs 3 to 5
    localparam logic [4:0] OP_PWM_PTR  = 5'h0E;  // PWM channel pointer
    localparam logic [1:0] OP_DISP_PTR = 2'h2;   // Display RAM pointer
    // Register select values of the control byte
    localparam logic [1:0] RS_COMMAND  = 2'h0;   // Command bytes follow
    localparam logic [1:0] RS_RAM_DATA = 2'h1;   // Display RAM data bytes follow
    // Multiplex mode encodings
    localparam logic [1:0] MUX_1_8     = 2'h0;   // Eight backplanes
    localparam logic [1:0] MUX_1_6     = 2'h1;   // Six backplanes
    localparam logic [1:0] MUX_1_4     = 2'h2;   // Four backplanes
    // Pointer limits and reset values
    localparam logic [5:0] DP_MAX_1_8  = 6'h27;  // Last address, 1:8
    localparam logic [5:0] DP_MAX_1_6  = 6'h29;  // Last address, 1:6
    localparam logic [5:0] DP_MAX_1_4  = 6'h2B;  // Last address, 1:4
    localparam logic [2:0] PP_MAX      = 3'h5;   // Last PWM channel
    localparam logic [5:0] DP_RESET    = 6'h00;  // Display pointer default
    localparam logic [2:0] PP_RESET    = 3'h0;   // PWM pointer default
    localparam logic [5:0] GPO_RESET   = 6'h00;  // Static outputs default
    localparam logic [5:0] DP_ONE      = 6'h01;  // Pointer step
endpackage : lcdcmd_pkg
`default_nettype wire

// file: hdl/lcdcmd_buf.sv
// Two-entry valid/ready buffer in the received-byte path
`timescale 1ns/1ps
`default_nettype none
module lcdcmd_buf (
    input  wire logic                          clk,
    input  wire logic                          resetn,
    input  wire logic                          in_valid,
    output var  logic                          in_ready,
    input  wire logic [lcdcmd_pkg::CMD_W-1:0]  in_data,
    input  wire logic                          in_rs,
    output var  logic                          out_valid,
    input  wire logic                          out_ready,
    output var  logic [lcdcmd_pkg::CMD_W-1:0]  out_data,
    output var  logic                          out_rs
);
    // Storage: each entry keeps the byte and its data-or-command flag
    logic [lcdcmd_pkg::CMD_W:0] mem_q [lcdcmd_pkg::BUF_DEPTH];
    logic                       wr_q;      // Write slot
    logic                       rd_q;      // Read slot
    logic [1:0]                 cnt_q;     // Occupancy
    logic                       push;
    logic                       pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    // Full and empty come straight from the occupancy count
    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rd_q][lcdcmd_pkg::CMD_W-1:0];
    assign out_rs    = mem_q[rd_q][lcdcmd_pkg::CMD_W];

    // Storage write; no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= {in_rs, in_data};
        end
    end

    // Pointers and count
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : lcdcmd_buf
`default_nettype wire

// file: hdl/lcdcmd_top.sv
// Command decoder: static outputs, display and PWM pointers, display RAM writes
`timescale 1ns/1ps
`default_nettype none
module lcdcmd_top (
    input  wire logic                               clk,
    input  wire logic                               resetn,
    input  wire logic                               byte_valid,       // Received byte strobe
    output logic                                    byte_ready,       // Buffer can accept
    input  wire logic [lcdcmd_pkg::CMD_W-1:0]       byte_data,        // Received byte
    input  wire logic [1:0]                         register_select,  // From the last control byte
    input  wire logic [1:0]                         mux_mode,         // Current multiplex mode
    input  wire logic [lcdcmd_pkg::GPO_N-1:0]       pin_pwm_mode,     // 1 = pin driven by PWM
    input  wire logic [lcdcmd_pkg::GPO_N-1:0]       pwm_wave,         // PWM waveforms
    input  wire logic                               ram_rd_en,        // Display scan read
    input  wire logic [lcdcmd_pkg::DP_W-1:0]        ram_rd_addr,      // Display scan address
    output logic [lcdcmd_pkg::CMD_W-1:0]            ram_rd_data,      // Display scan data
    output logic [lcdcmd_pkg::GPO_N-1:0]            aux_out_pin,      // Pins 0 to 5
    output logic [lcdcmd_pkg::DP_W-1:0]             display_ram_pointer,
    output logic                                    display_ptr_valid,
    output logic [lcdcmd_pkg::PP_W-1:0]             pwm_channel_pointer,
    output logic                                    pwm_ptr_valid
);
    // Buffer outputs
    logic                            b_valid;   // Byte waiting
    logic [lcdcmd_pkg::CMD_W-1:0]    b_data;    // Buffered byte
    logic                            b_rs;      // Byte is display data
    logic                            take;      // Byte consumed this cycle
    // Command registers
    logic [lcdcmd_pkg::GPO_N-1:0]    static_out_q;  // Static bits 0..5
    logic [lcdcmd_pkg::DP_W-1:0]     dp_q;          // Display pointer
    logic                            dp_ok_q;       // Display pointer usable
    logic [lcdcmd_pkg::PP_W-1:0]     pp_q;          // PWM pointer
    logic                            pp_ok_q;       // PWM pointer usable
    logic [lcdcmd_pkg::DP_W-1:0]     dp_max;        // Limit for the mode
    // Decode strobes
    logic                            is_cmd;
    logic                            cmd_gpo_lo;
    logic                            cmd_gpo_hi;
    logic                            cmd_pp;
    logic                            cmd_dp;
    logic                            wr_ram;
    logic                            ready_q;
    // Display RAM: kept outside reset so contents survive the reset pin
    logic [lcdcmd_pkg::CMD_W-1:0]    ram_q [lcdcmd_pkg::RAM_DEPTH];

    // Byte buffer; the decoder always drains, but any back-pressure reaches the pin side
    lcdcmd_buf u_buf (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (byte_valid),
        .in_ready  (ready_q),
        .in_data   (byte_data),
        .in_rs     (register_select == lcdcmd_pkg::RS_RAM_DATA),
        .out_valid (b_valid),
        .out_ready (1'b1),
        .out_data  (b_data),
        .out_rs    (b_rs)
    );

    // Ready comes from the buffer combinationally; register it with a one-byte margin
    // would break the handshake, so it is the one output allowed to pass through
    assign byte_ready = ready_q;
    assign take       = b_valid;

    // Mode limit selection
    // Mode-dependent limit
    always_comb begin
        case (mux_mode)
            lcdcmd_pkg::MUX_1_6: dp_max = lcdcmd_pkg::DP_MAX_1_6;
            lcdcmd_pkg::MUX_1_4: dp_max = lcdcmd_pkg::DP_MAX_1_4;
            default:             dp_max = lcdcmd_pkg::DP_MAX_1_8;
        endcase
    end

    // Opcode decode on command bytes only
    assign is_cmd     = take && !b_rs;
    assign cmd_gpo_lo = is_cmd && (b_data[lcdcmd_pkg::OP5_HI:lcdcmd_pkg::OP5_LO] == lcdcmd_pkg::OP_GPO_LOW);
    assign cmd_gpo_hi = is_cmd && (b_data[lcdcmd_pkg::OP5_HI:lcdcmd_pkg::OP5_LO] == lcdcmd_pkg::OP_GPO_HIGH);
    assign cmd_pp     = is_cmd && (b_data[lcdcmd_pkg::OP5_HI:lcdcmd_pkg::OP5_LO] == lcdcmd_pkg::OP_PWM_PTR);
    assign cmd_dp     = is_cmd && (b_data[lcdcmd_pkg::OP5_HI:lcdcmd_pkg::OP2_LO] == lcdcmd_pkg::OP_DISP_PTR);
    // Data path only with select 01
    // No write without a valid pointer
    // Range test as well: a mode change can shrink the limit one edge before the flag drops
    assign wr_ram     = take && b_rs && dp_ok_q && (dp_q <= dp_max);

    // Static output bits
    always_ff @(posedge clk) begin
        if (!resetn) begin
            static_out_q <= lcdcmd_pkg::GPO_RESET;
        end else if (cmd_gpo_lo) begin
            static_out_q[0] <= b_data[0];
            static_out_q[1] <= b_data[1];
            static_out_q[2] <= b_data[2];
        end else if (cmd_gpo_hi) begin
            static_out_q[3] <= b_data[0];
            static_out_q[4] <= b_data[1];
            static_out_q[5] <= b_data[2];
        end
    end

    // Pin drivers: one per output, static level or PWM waveform
    genvar gi;
    generate
        for (gi = 0; gi < lcdcmd_pkg::GPO_N; gi++) begin : g_pin
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    aux_out_pin[gi] <= 1'b0;
                end else begin
                    aux_out_pin[gi] <= pin_pwm_mode[gi] ? pwm_wave[gi] : static_out_q[gi];
                end
            end
        end
    endgenerate

    // Display pointer: load, increment, invalidate
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dp_q    <= lcdcmd_pkg::DP_RESET;
            dp_ok_q <= 1'b1;
        end else if (cmd_dp) begin
            dp_q    <= b_data[lcdcmd_pkg::DP_W-1:0];
            dp_ok_q <= (b_data[lcdcmd_pkg::DP_W-1:0] <= dp_max);
        end else if (wr_ram) begin
            dp_q    <= dp_q + lcdcmd_pkg::DP_ONE;
            dp_ok_q <= (dp_q < dp_max);
        end else if (dp_q > dp_max) begin
            // A mode change can shrink the range under a live pointer
            dp_ok_q <= 1'b0;
        end
    end

    // PWM pointer
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pp_q    <= lcdcmd_pkg::PP_RESET;
            pp_ok_q <= 1'b1;
        end else if (cmd_pp) begin
            pp_q    <= b_data[lcdcmd_pkg::PP_W-1:0];
            pp_ok_q <= (b_data[lcdcmd_pkg::PP_W-1:0] <= lcdcmd_pkg::PP_MAX);
        end
    end

    // Display RAM write, never reset
    // Contents survive reset
    always_ff @(posedge clk) begin
        if (wr_ram) begin
            ram_q[dp_q] <= b_data;
        end
    end

    // Display scan read port, registered
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ram_rd_data <= '0;
        end else if (ram_rd_en && (ram_rd_addr <= lcdcmd_pkg::DP_MAX_1_4)) begin
            ram_rd_data <= ram_q[ram_rd_addr];
        end
    end

    // Pointer outputs
    always_ff @(posedge clk) begin
        if (!resetn) begin
            display_ram_pointer <= lcdcmd_pkg::DP_RESET;
            display_ptr_valid   <= 1'b0;
            pwm_channel_pointer <= lcdcmd_pkg::PP_RESET;
            pwm_ptr_valid       <= 1'b0;
        end else begin
            display_ram_pointer <= dp_q;
            display_ptr_valid   <= dp_ok_q;
            pwm_channel_pointer <= pp_q;
            pwm_ptr_valid       <= pp_ok_q;
        end
    end

    // Checks
    // chk_gpo_low_load
    chk_gpo_low_load: assert property (@(posedge clk) disable iff (!resetn)
        cmd_gpo_lo |=> static_out_q[2:0] == $past(b_data[2:0]))
        else $error("static low bank not loaded");
    chk_gpo_high_load: assert property (@(posedge clk) disable iff (!resetn)
        cmd_gpo_hi |=> static_out_q[5:3] == $past(b_data[2:0]))
        else $error("static high bank not loaded");
    chk_pin_static_level: assert property (@(posedge clk) disable iff (!resetn)
        !pin_pwm_mode[0] |=> aux_out_pin[0] == $past(static_out_q[0]))
        else $error("static pin level wrong");
    chk_dp_load_value: assert property (@(posedge clk) disable iff (!resetn)
        cmd_dp |=> dp_q == $past(b_data[5:0]))
        else $error("display pointer not loaded");
    chk_dp_increment: assert property (@(posedge clk) disable iff (!resetn)
        wr_ram && !cmd_dp |=> dp_q == $past(dp_q) + 6'h01)
        else $error("display pointer did not step");
    chk_dp_range_reject: assert property (@(posedge clk) disable iff (!resetn)
        cmd_dp && (b_data[5:0] > dp_max) |=> !dp_ok_q)
        else $error("bad display pointer accepted");
    chk_pp_range_reject: assert property (@(posedge clk) disable iff (!resetn)
        cmd_pp && (b_data[2:0] > 3'h5) |=> !pp_ok_q)
        else $error("bad pwm pointer accepted");
    chk_write_gate_rs: assert property (@(posedge clk) disable iff (!resetn)
        take && !b_rs && !cmd_dp |=> dp_q == $past(dp_q))
        else $error("command byte moved the display pointer");
    chk_ram_byte_store: assert property (@(posedge clk) disable iff (!resetn)
        wr_ram |=> ram_q[$past(dp_q)] == $past(b_data))
        else $error("display byte not stored");
    chk_dp_wrap_stop: assert property (@(posedge clk) disable iff (!resetn)
        wr_ram && !cmd_dp && dp_q == dp_max |=> !dp_ok_q)
        else $error("pointer past limit still valid");
    chk_reset_pointers: assert property (@(posedge clk)
        !resetn |=> dp_q == 6'h00 && pp_q == 3'h0)
        else $error("pointers not cleared");
    cov_ram_write:  cover property (@(posedge clk) disable iff (!resetn) wr_ram);
    cov_dp_reject:  cover property (@(posedge clk) disable iff (!resetn) cmd_dp && b_data[5:0] > dp_max);
    cov_buf_full:   cover property (@(posedge clk) disable iff (!resetn) !ready_q);
    cov_gpo_high:   cover property (@(posedge clk) disable iff (!resetn) cmd_gpo_hi);
endmodule : lcdcmd_top
`default_nettype wire

// file: sim/lcdcmd_host.sv
// Host model that hands received bytes to the command decoder
`timescale 1ns/1ps
`default_nettype none
module lcdcmd_host (
    input  wire logic       clk,
    input  wire logic       byte_ready,
    output var  logic       byte_valid,
    output var  logic [7:0] byte_data,
    output var  logic [1:0] register_select
);
    // Idle lines at time zero, nothing offered
    initial begin
        byte_valid      = 1'b0;
        byte_data       = 8'hA5;
        register_select = 2'h3;
    end

    // select code travels with every byte
    // Offer one byte and hold it until an edge samples ready high
    task automatic send(input logic [7:0] b, input logic [1:0] rs);
        logic rdy;
        byte_valid      = 1'b1;
        byte_data       = b;
        register_select = rs;
        do begin
            rdy = byte_ready;
            @(posedge clk);
            #1;
        end while (rdy !== 1'b1);
    endtask : send

    // Release; a stale value could hide a late sample, so invert it
    task automatic idle();
        byte_valid      = 1'b0;
        byte_data       = ~byte_data;
        register_select = ~register_select;
    endtask : idle
endmodule : lcdcmd_host
`default_nettype wire

// file: sim/lcdcmd_top_tb.sv
// Self-checking testbench of the command decoder
`timescale 1ns/1ps
`default_nettype none
module lcdcmd_top_tb;
    logic       clk = 1'b0;         // 200 MHz
    logic       resetn = 1'b0;      // Sync, active low
    logic       byte_valid;         // From host model
    logic       byte_ready;         // Buffer room
    logic [7:0] byte_data;          // Offered byte
    logic [1:0] register_select;    // Tag of the byte
    logic [1:0] mux_mode = 2'h0;    // Multiplex mode
    logic [5:0] pin_pwm_mode = 6'h00;
    logic [5:0] pwm_wave = 6'h00;
    logic       ram_rd_en = 1'b0;   // Scan read strobe
    logic [5:0] ram_rd_addr = 6'h00;
    logic [7:0] ram_rd_data;
    logic [5:0] aux_out_pin;
    logic [5:0] display_ram_pointer;
    logic       display_ptr_valid;
    logic [2:0] pwm_channel_pointer;
    logic       pwm_ptr_valid;
    int         n_fail = 0;         // Mismatches seen
    int         check_count = 0;    // Compares made
    logic [7:0] d;                  // Read-back scratch

    always #2.5 clk = ~clk;

    lcdcmd_top dut (.clk(clk), .resetn(resetn), .byte_valid(byte_valid), .byte_ready(byte_ready),
        .byte_data(byte_data), .register_select(register_select), .mux_mode(mux_mode),
        .pin_pwm_mode(pin_pwm_mode), .pwm_wave(pwm_wave), .ram_rd_en(ram_rd_en),
        .ram_rd_addr(ram_rd_addr), .ram_rd_data(ram_rd_data), .aux_out_pin(aux_out_pin),
        .display_ram_pointer(display_ram_pointer), .display_ptr_valid(display_ptr_valid),
        .pwm_channel_pointer(pwm_channel_pointer), .pwm_ptr_valid(pwm_ptr_valid));

    lcdcmd_host host (.clk(clk), .byte_ready(byte_ready), .byte_valid(byte_valid),
        .byte_data(byte_data), .register_select(register_select));

    // Compare and count; four-state equality so X never matches
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // All flow stays 1 ns after the rising edge
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_n

    // One byte, then wait out the three-edge decode path
    task automatic cmd(input logic [7:0] b, input logic [1:0] rs);
        host.send(b, rs);
        host.idle();
        wait_n(4);
    endtask : cmd

    // Scan read; data is registered one edge after the address
    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        ram_rd_en   = 1'b1;
        ram_rd_addr = a;
        wait_n(2);
        v = ram_rd_data;
    endtask : rd

    task automatic dp(input logic [5:0] p, input logic v);
        check({1'b0, display_ptr_valid, display_ram_pointer}, {1'b0, v, p});
    endtask : dp

    task automatic pp(input logic [2:0] p, input logic v);
        check({4'h0, pwm_ptr_valid, pwm_channel_pointer}, {4'h0, v, p});
    endtask : pp

    // Static outputs, bit order and the static/PWM selection
    task automatic t_static();
        cmd(8'h65, 2'h0);
        cmd(8'h6A, 2'h0);
        check({2'h0, aux_out_pin}, 8'h15);
        pin_pwm_mode = 6'h01;
        wait_n(3);
        check({2'h0, aux_out_pin}, 8'h14);
        pin_pwm_mode = 6'h00;
        wait_n(3);
        check({2'h0, aux_out_pin}, 8'h15);
    endtask : t_static

    // PWM pointer: top valid value, first invalid, back to zero
    task automatic t_pwm();
        cmd(8'h75, 2'h0);
        pp(3'h5, 1'b1);
        cmd(8'h76, 2'h0);
        check({7'h00, pwm_ptr_valid}, 8'h00);
        cmd(8'h70, 2'h0);
        pp(3'h0, 1'b1);
    endtask : t_pwm

    // Display pointer limits per mode, overrun and refusals
    task automatic t_disp();
        logic [5:0] lim;
        for (int m = 0; m < 3; m++) begin
            mux_mode = m[1:0];
            lim = 6'h27 + 6'(2 * m);
            cmd({2'h2, lim}, 2'h0);
            dp(lim, 1'b1);
            // host fills RAM before reading it
            cmd(8'hC0 + 8'(m), 2'h1);
            check({7'h00, display_ptr_valid}, 8'h00);
            rd(lim, d);
            check(d, 8'hC0 + 8'(m));
            cmd({2'h2, lim + 6'h01}, 2'h0);
            check({7'h00, display_ptr_valid}, 8'h00);
        end
        // Mode code 11 acts as 1:8, so a live pointer of 43 falls out of range
        cmd(8'hAB, 2'h0);
        dp(6'h2B, 1'b1);
        mux_mode = 2'h3;
        wait_n(3);
        check({7'h00, display_ptr_valid}, 8'h00);
        mux_mode = 2'h0;
        cmd(8'h90, 2'h0);
        host.send(8'h5A, 2'h1);
        host.send(8'hA5, 2'h1);
        host.idle();
        wait_n(4);
        dp(6'h12, 1'b1);
        rd(6'h10, d);
        check(d, 8'h5A);
        rd(6'h11, d);
        check(d, 8'hA5);
        // Non-display select: the byte must neither land in RAM nor step the pointer
        cmd(8'h19, 2'h2);
        dp(6'h12, 1'b1);
        cmd(8'h93, 2'h0);
        cmd(8'h3C, 2'h1);
        cmd(8'h93, 2'h0);
        cmd(8'hBF, 2'h0);
        cmd(8'h77, 2'h1);
        rd(6'h13, d);
        check(d, 8'h3C);
    endtask : t_disp

    // Mid-run reset: registers back to default, RAM kept
    task automatic t_rst();
        resetn = 1'b0;
        wait_n(12);
        resetn = 1'b1;
        wait_n(3);
        dp(6'h00, 1'b1);
        pp(3'h0, 1'b1);
        check({2'h0, aux_out_pin}, 8'h00);
        rd(6'h10, d);
        check(d, 8'h5A);
    endtask : t_rst

    task automatic complete_run();
        if (n_fail == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    // Main sequence
    initial begin
        wait_n(12);
        resetn = 1'b1;
        wait_n(3);
        dp(6'h00, 1'b1);
        check({2'h0, aux_out_pin}, 8'h00);
        t_static();
        t_pwm();
        t_disp();
        t_rst();
        complete_run();
    end

    // Watchdog: tests need well under 1000 cycles, allow 20000
    initial begin
        #100000;
        n_fail++;
        complete_run();
    end
endmodule : lcdcmd_top_tb
`default_nettype wire
